// >>> bench/accel_data_event_core_assertions.sv
// Concurrent checks on the ports of the accelerometer data and event core.
// Assumes it is bound onto the core; mclk is the only clock.
`timescale 1ns/100ps
module accel_core_checker (
  input logic mclk,
  input logic rstn,
  input accel_pkg::reg_req_s reg_req,
  input logic [7:0] reg_rdata,
  input logic trim_rd,
  input logic [2:0] trim_addr,
  input logic analog_en,
  input logic [2:0] odr_sel,
  input logic [1:0] oversample_sel,
  input logic sleep_state,
  input logic event_pin_one,
  input logic event_pin_two
);
  // ----------------------------------------------------------------
  // Shadow of the control bits, rebuilt from the writes seen
  // ----------------------------------------------------------------
  logic fast_q;
  logic auto_q;
  logic lo_rd;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      fast_q <= 1'b0;
      auto_q <= 1'b0;
    end else if (reg_req.wr) begin
      if (reg_req.addr == accel_pkg::ADDR_PRIMARY_CFG) begin
        fast_q <= reg_req.wdata[1];
      end
      if (reg_req.addr == accel_pkg::ADDR_SECOND_CFG) begin
        auto_q <= reg_req.wdata[2];
      end
    end
  end
  assign lo_rd = reg_req.rd && (reg_req.addr == accel_pkg::ADDR_X_LO ||
    reg_req.addr == accel_pkg::ADDR_Y_LO || reg_req.addr == accel_pkg::ADDR_Z_LO);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  AST_TRIM_START: assert property (rstn && !$past(rstn) |=> trim_rd && trim_addr == 3'h0)
    else $error("trim fetch did not start after reset");
  AST_TRIM_STEP: assert property (trim_rd && trim_addr < 3'h5 |->
    ##2 trim_rd && trim_addr == $past(trim_addr, 2) + 3'h1)
    else $error("trim word order broken");
  AST_TRIM_GAP: assert property (trim_rd |=> !trim_rd)
    else $error("trim request longer than one cycle");
  AST_TRIM_RANGE: assert property (trim_rd |-> trim_addr <= 3'h5)
    else $error("trim index out of range");
  AST_ACTIVE_CTRL: assert property (reg_req.wr && reg_req.addr == accel_pkg::ADDR_PRIMARY_CFG
    |=> analog_en == $past(reg_req.wdata[0]))
    else $error("analog enable does not follow active bit");
  AST_OVS_CTRL: assert property (reg_req.wr && reg_req.addr == accel_pkg::ADDR_SECOND_CFG
    |=> oversample_sel == $past(reg_req.wdata[1:0]))
    else $error("oversampling select does not follow its field");
  AST_SLEEP_RATE: assert property (sleep_state && $past(sleep_state) |-> odr_sel[2])
    else $error("sleep without the sleep rate code");
  AST_SLEEP_AUTO: assert property ($rose(sleep_state) |-> auto_q)
    else $error("fell asleep with auto sleep off");
  AST_LOW_BYTE: assert property (lo_rd ##1 !reg_req.rd |=> reg_rdata[5:0] == 6'h00)
    else $error("low byte unused bits not zero");
  AST_FAST_LOW: assert property (lo_rd && fast_q ##1 !reg_req.rd |=> reg_rdata == 8'h00)
    else $error("low byte not zero in fast read");
  AST_PIN_CAUSE: assert property ($rose(event_pin_one) || $rose(event_pin_two)
    |-> analog_en || $past(reg_req.wr))
    else $error("event pin rose without a cause");
endmodule

// >>> bench/test_accel_data_event_core.sv
// Self-checking bench for the accelerometer data and event core.
// Assumes the trim storage model on the trim port; the bench plays the host.
`timescale 1ns/100ps
module test_accel_data_event_core;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  accel_pkg::sample_in_s sample_in = '0;
  accel_pkg::reg_req_s reg_req = '0;
  logic [7:0] trim_data, reg_rdata, rd_v;
  logic trim_rd, analog_en, sleep_state, event_pin_one, event_pin_two;
  logic [2:0] trim_addr, odr_sel;
  logic [1:0] oversample_sel;
  logic [9:0] e;
  logic [7:0] uoff [3];
  logic [15:0] setup [8] = '{16'h0e00, 16'h2d02, 16'h2e00, 16'h1f08,
    16'h2001, 16'h1d80, 16'h2902, 16'h2a01};
  int n_fail = 0;
  int checks = 0;
  int gain [3] = '{128, 64, 128};
  int zoff [3] = '{16, 0, -16};
  int raw [3];

  always #5 mclk = ~mclk;

  accel_data_event_core dut_u (.mclk(mclk), .rstn(rstn), .sample_in(sample_in),
    .trim_data(trim_data), .reg_req(reg_req), .reg_rdata(reg_rdata), .trim_rd(trim_rd),
    .trim_addr(trim_addr), .analog_en(analog_en), .odr_sel(odr_sel),
    .oversample_sel(oversample_sel), .sleep_state(sleep_state),
    .event_pin_one(event_pin_one), .event_pin_two(event_pin_two));
  trim_store_model trim_u (.mclk(mclk), .trim_rd(trim_rd), .trim_addr(trim_addr),
    .trim_data(trim_data));

  // ----------------------------------------------------------------
  // Host tasks and expectations
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [9:0] exp, input logic [9:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_req.wr = 1'b1;
    reg_req.addr = a;
    reg_req.wdata = d;
    @(negedge mclk);
    reg_req.wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge mclk);
    reg_req.rd = 1'b1;
    reg_req.addr = a;
    @(negedge mclk);
    reg_req.rd = 1'b0;
    @(negedge mclk);
    rd_v = reg_rdata;
  endtask
  task automatic smp(input int x, input int y, input int z);
    @(negedge mclk);
    raw = '{x, y, z};
    sample_in.valid = 1'b1;
    for (int i = 0; i < 3; i++) begin
      sample_in.raw[i] = 14'(raw[i]);
    end
    @(negedge mclk);
    sample_in.valid = 1'b0;
    sample_in.raw = ~sample_in.raw;
  endtask
  // Raw values other than the 2028 and -2064 samples are kept multiples of 32 so trim and scaling divide exactly
  function automatic logic [9:0] expv(input int i, input int rng);
    int v;
    v = (raw[i] * gain[i]) / 128 + zoff[i];
    v = (v >>> (2 + rng)) + int'($signed(uoff[i]));
    if (v > 511) v = 511;
    if (v < -512) v = -512;
    return 10'(v);
  endfunction
  task automatic chk_axes(input int rng, input logic fast);
    for (int i = 0; i < 3; i++) begin
      e = expv(i, rng);
      rd(accel_pkg::ADDR_X_HI + 8'(2 * i));
      chk("high byte", {2'h0, e[9:2]}, {2'h0, rd_v});
      rd(accel_pkg::ADDR_X_LO + 8'(2 * i));
      chk("low byte", fast ? 10'h000 : {2'h0, e[1:0], 6'h00}, {2'h0, rd_v});
    end
  endtask
  task automatic complete_run();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #100us;
    n_fail++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h99c6f4fa));
    repeat (12) @(posedge mclk);
    @(negedge mclk);
    rstn = 1'b1;
    chk("analog enable", 10'h0, {9'h0, analog_en});
    chk("pins", 10'h0, {8'h0, event_pin_one, event_pin_two});
    repeat (14) @(negedge mclk);
    for (int i = 0; i < 3; i++) begin
      uoff[i] = 8'($urandom);
      wr(accel_pkg::ADDR_X_USER_OFF + 8'(i), uoff[i]);
      rd(accel_pkg::ADDR_X_USER_OFF + 8'(i));
      chk("user offset", {2'h0, uoff[i]}, {2'h0, rd_v});
    end
    for (int m = 0; m < 4; m++) begin
      wr(accel_pkg::ADDR_SECOND_CFG, 8'(m));
      chk("oversampling", 10'(m), {8'h0, oversample_sel});
    end
    wr(accel_pkg::ADDR_INT_EN, 8'h01);
    wr(accel_pkg::ADDR_INT_ROUTE, 8'h01);
    for (int r = 0; r < 3; r++) begin
      for (int f = 0; f < 2; f++) begin
        wr(accel_pkg::ADDR_RANGE_CFG, 8'(r));
        wr(accel_pkg::ADDR_PRIMARY_CFG, 8'(1 + 2 * f));
        chk("analog enable", 10'h1, {9'h0, analog_en});
        smp(32 * (int'($urandom_range(63)) - 32), 32 * (int'($urandom_range(63)) - 32),
          32 * (int'($urandom_range(63)) - 32));
        chk("pins", 10'h2, {8'h0, event_pin_one, event_pin_two});
        chk_axes(r, f[0]);
        rd(accel_pkg::ADDR_EVENT_SRC);
        chk("ready flag", 10'h1, {9'h0, rd_v[0]});
        chk("pin one", 10'h0, {9'h0, event_pin_one});
      end
    end
    // Standby must refuse samples yet keep registers reachable
    wr(accel_pkg::ADDR_PRIMARY_CFG, 8'h00);
    e = expv(0, 2);
    smp(512, 512, 512);
    rd(accel_pkg::ADDR_X_HI);
    chk("standby sample", {2'h0, e[9:2]}, {2'h0, rd_v});
    chk("analog enable", 10'h0, {9'h0, analog_en});
    for (int i = 0; i < 3; i++) begin
      uoff[i] = 8'h00;
      wr(accel_pkg::ADDR_X_USER_OFF + 8'(i), 8'h00);
    end
    for (int k = 0; k < 8; k++) begin
      wr(setup[k][15:8], setup[k][7:0]);
    end
    smp(2028, 2028, 2028);
    chk_axes(0, 1'b0);
    smp(-2064, -2064, -2064);
    chk_axes(0, 1'b0);
    // Freefall: a loud sample in the run must restart the count
    smp(0, 0, 0);
    smp(1024, 1024, 1024);
    smp(0, 0, 0);
    chk("freefall early", 10'h0, {9'h0, event_pin_two});
    smp(0, 0, 0);
    chk("freefall pin", 10'h1, {9'h0, event_pin_two});
    rd(accel_pkg::ADDR_EVENT_SRC);
    chk("freefall flag", 10'h1, {9'h0, rd_v[1]});
    wr(accel_pkg::ADDR_SECOND_CFG, 8'h04);
    for (int k = 0; k < 8 && sleep_state !== 1'b1; k++) begin
      smp(1024, 0, 0);
    end
    chk("asleep", 10'h1, {9'h0, sleep_state});
    chk("sleep rate", 10'h1, {9'h0, odr_sel[2]});
    smp(1024, 0, 0);
    chk("ready keeps asleep", 10'h1, {9'h0, sleep_state});
    smp(0, 0, 0);
    smp(0, 0, 0);
    chk("woken", 10'h0, {9'h0, sleep_state});
    complete_run();
  end
endmodule

bind accel_data_event_core accel_core_checker chk_u (.mclk(mclk), .rstn(rstn),
  .reg_req(reg_req), .reg_rdata(reg_rdata), .trim_rd(trim_rd), .trim_addr(trim_addr),
  .analog_en(analog_en), .odr_sel(odr_sel), .oversample_sel(oversample_sel),
  .sleep_state(sleep_state), .event_pin_one(event_pin_one), .event_pin_two(event_pin_two));

// >>> bench/trim_store_model.sv
// Behavioural factory trim storage feeding the core at power-up.
// Assumes trim requests arrive on mclk; a word is shown in the same cycle as its request.
`timescale 1ns/100ps
module trim_store_model #(
  parameter logic [47:0] WORDS = 48'hf0_00_10_80_40_80
) (
  input logic mclk,
  input logic trim_rd,
  input logic [2:0] trim_addr,
  output logic [7:0] trim_data
);
  logic [7:0] junk_q = 8'h5a;
  // The core takes the word at the edge that ends its request cycle, so the word
  // must stand while the request does; outside it the bus toggles, so a late
  // or early sample never sees valid trim
  always @(posedge mclk) begin
    junk_q <= ~junk_q;
  end
  assign trim_data = trim_rd ? WORDS[trim_addr*8 +: 8] : junk_q;
endmodule

// >>> common/accel_pkg.sv
// Constants, register map and carrier types for the accelerometer data and event core.
// Assumes one 100 MHz clock (mclk) with a synchronous active-low reset.
package accel_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int AXES = 3;
  localparam int RAW_W = 14;
  localparam int SMP_W = 10;
  localparam int TRIM_WORDS = 6;
  localparam int CLK_PERIOD_NS = 10;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_X_HI = 8'h01;
  localparam logic [7:0] ADDR_X_LO = 8'h02;
  localparam logic [7:0] ADDR_Y_HI = 8'h03;
  localparam logic [7:0] ADDR_Y_LO = 8'h04;
  localparam logic [7:0] ADDR_Z_HI = 8'h05;
  localparam logic [7:0] ADDR_Z_LO = 8'h06;
  localparam logic [7:0] ADDR_SYS_MODE = 8'h0b;
  localparam logic [7:0] ADDR_EVENT_SRC = 8'h0c;
  localparam logic [7:0] ADDR_RANGE_CFG = 8'h0e;
  localparam logic [7:0] ADDR_ORIENT = 8'h10;
  localparam logic [7:0] ADDR_FF_CFG = 8'h1d;
  localparam logic [7:0] ADDR_FF_THRESH = 8'h1f;
  localparam logic [7:0] ADDR_FF_COUNT = 8'h20;
  localparam logic [7:0] ADDR_SLEEP_TO = 8'h29;
  localparam logic [7:0] ADDR_PRIMARY_CFG = 8'h2a;
  localparam logic [7:0] ADDR_SECOND_CFG = 8'h2b;
  localparam logic [7:0] ADDR_INT_EN = 8'h2d;
  localparam logic [7:0] ADDR_INT_ROUTE = 8'h2e;
  localparam logic [7:0] ADDR_X_USER_OFF = 8'h2f;
  localparam logic [7:0] ADDR_Y_USER_OFF = 8'h30;
  localparam logic [7:0] ADDR_Z_USER_OFF = 8'h31;

  // ----------------------------------------------------------------
  // Field positions and codes
  // ----------------------------------------------------------------
  localparam int CFG1_ACTIVE = 0;
  localparam int CFG1_FAST_READ = 1;
  localparam int CFG1_WAKE_RATE_LO = 3;
  localparam int CFG1_SLEEP_RATE_LO = 6;
  localparam int CFG2_AUTO_SLEEP = 2;
  localparam int FF_CFG_ENABLE = 7;
  localparam int EV_DRDY = 0;
  localparam int EV_FREEFALL = 1;
  localparam int EV_ORIENT = 2;
  localparam int EV_WAKE_SLEEP = 3;
  localparam logic [1:0] OVS_HIGH_RES = 2'h2;
  localparam logic [1:0] OVS_LOW_POWER = 2'h3;
  localparam logic [1:0] RANGE_8G = 2'h2;
  localparam logic [9:0] COUNTS_PER_G_2G = 10'h100;
  localparam logic [2:0] BASE_SHIFT = 3'h2;

  // ----------------------------------------------------------------
  // Reset value and counter limits
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_GAIN = 8'h80;
  localparam logic [8:0] SLEEP_CNT_MAX = 9'h1ff;
  localparam logic [7:0] FF_CNT_MAX = 8'hff;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {TRIM_REQ, TRIM_WAIT, RUN} phase_e;

  typedef struct packed {
    logic valid;
    logic [AXES-1:0][RAW_W-1:0] raw;
  } sample_in_s;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    phase_e phase;
    logic [2:0] trim_idx;
    logic [AXES-1:0][7:0] gain;
    logic [AXES-1:0][7:0] zoff;
    logic [AXES-1:0][7:0] user_off;
    logic [AXES-1:0][SMP_W-1:0] sample;
    logic [7:0] cfg1;
    logic [7:0] cfg2;
    logic [7:0] range_cfg;
    logic [7:0] ff_cfg;
    logic [7:0] ff_thresh;
    logic [7:0] ff_count;
    logic [7:0] sleep_to;
    logic [7:0] int_en;
    logic [7:0] int_route;
    logic [7:0] ff_cnt;
    logic [8:0] sleep_cnt;
    logic asleep;
    logic [2:0] orient;
    logic [3:0] flags;
    logic was_active;
    logic [7:0] rdata;
    logic pin_one;
    logic pin_two;
    logic trim_rd;
    logic [2:0] trim_addr;
    logic [2:0] odr;
  } core_state_s;

endpackage

// >>> src/accel_data_event_core.sv
// Accelerometer data and event core: trim load, sample formatting, freefall,
// orientation, auto wake/sleep and event pin routing.
// Assumes samples and trim words arrive from same-clock logic; register requests
// come from the serial interface engine on mclk.
`timescale 1ns/100ps
module accel_data_event_core (
  input logic mclk,
  input logic rstn,
  input accel_pkg::sample_in_s sample_in,
  input logic [7:0] trim_data,
  input accel_pkg::reg_req_s reg_req,
  output logic [7:0] reg_rdata,
  output logic trim_rd,
  output logic [2:0] trim_addr,
  output logic analog_en,
  output logic [2:0] odr_sel,
  output logic [1:0] oversample_sel,
  output logic sleep_state,
  output logic event_pin_one,
  output logic event_pin_two
);

  accel_pkg::core_state_s q;
  accel_pkg::core_state_s d;

  // ----------------------------------------------------------------
  // Per-axis datapath
  // ----------------------------------------------------------------
  logic [1:0] range_sel;
  logic [2:0] shift_amt;
  logic [accel_pkg::AXES-1:0][accel_pkg::SMP_W-1:0] cooked;
  logic [accel_pkg::AXES-1:0][accel_pkg::SMP_W-1:0] mag;

  // Code 11 is undefined; it is treated as the widest range so nothing overflows
  assign range_sel = (q.range_cfg[1:0] > accel_pkg::RANGE_8G) ?
                     accel_pkg::RANGE_8G : q.range_cfg[1:0];
  assign shift_amt = accel_pkg::BASE_SHIFT + {1'b0, range_sel};

  function automatic logic [9:0] sat10(input logic signed [16:0] v);
    logic [9:0] r;
    if (v > 17'sd511) begin
      r = 10'h1ff;
    end else if (v < -17'sd512) begin
      r = 10'h200;
    end else begin
      r = v[9:0];
    end
    return r;
  endfunction

  for (genvar a = 0; a < accel_pkg::AXES; a++) begin : g_axis
    logic signed [22:0] prod;
    logic signed [16:0] trimmed;
    logic signed [16:0] scaled;
    logic [9:0] ranged;
    logic signed [16:0] with_user;
    // Gain 0x80 is unity; zero-g trim is in raw 1/1024 g units
    assign prod = $signed(sample_in.raw[a]) * $signed({1'b0, q.gain[a]});
    assign trimmed = 17'(prod >>> 7) + 17'($signed(q.zoff[a]));
    // Raw front-end data is 1/1024 g, so 2/3/4 bit shifts give 256/128/64 counts per g
    assign scaled = trimmed >>> shift_amt;
    assign ranged = sat10(scaled);
    assign with_user = 17'($signed(ranged)) + 17'($signed(q.user_off[a]));
    assign cooked[a] = sat10(with_user);
    assign mag[a] = cooked[a][9] ? 10'(-cooked[a]) : cooked[a];
  end

  // ----------------------------------------------------------------
  // Freefall and orientation decisions on the unfiltered samples
  // ----------------------------------------------------------------
  logic all_low;
  logic [9:0] one_g;
  logic z_locked;
  logic to_landscape;
  logic to_portrait;

  // No high-pass stage exists anywhere in this path
  assign all_low = (mag[0] < {2'b00, q.ff_thresh}) && (mag[1] < {2'b00, q.ff_thresh}) &&
                   (mag[2] < {2'b00, q.ff_thresh});
  assign one_g = accel_pkg::COUNTS_PER_G_2G >> range_sel;
  // Tilt under 29 degrees means |z| above about 0.875 g
  assign z_locked = {mag[2], 3'b000} > (13'({one_g, 3'b000}) - 13'(one_g));
  // tan 60 taken as 7/4: landscape below 30 degrees, portrait above 60
  assign to_landscape = (13'({mag[1], 3'b000}) - 13'(mag[1])) <
                        13'({mag[0], 2'b00});
  assign to_portrait = 13'({mag[1], 2'b00}) >
                       (13'({mag[0], 3'b000}) - 13'(mag[0]));

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic active;
  logic take;
  logic ff_evt;
  logic or_evt;
  logic [3:0] set_flags;
  logic [3:0] clr_flags;
  logic [2:0] new_orient;
  logic landscape;
  logic [8:0] cnt_next;
  logic [3:0] armed;

  always_comb begin
    d = q;
    active = q.cfg1[accel_pkg::CFG1_ACTIVE];
    take = active && (q.phase == accel_pkg::RUN) && sample_in.valid;
    ff_evt = 1'b0;
    or_evt = 1'b0;
    set_flags = 4'h0;
    clr_flags = 4'h0;
    new_orient = q.orient;
    landscape = q.orient[2];
    cnt_next = 9'h000;
    armed = 4'h0;
    d.trim_rd = 1'b0;
    d.was_active = active;

    // Trim fetch: one request, data valid in the same cycle as the request
    unique case (q.phase)
      accel_pkg::TRIM_REQ: begin
        d.trim_rd = 1'b1;
        d.trim_addr = q.trim_idx;
        d.phase = accel_pkg::TRIM_WAIT;
      end
      accel_pkg::TRIM_WAIT: begin
        if (q.trim_idx < 3'(accel_pkg::AXES)) begin
          d.gain[q.trim_idx[1:0]] = trim_data;
        end else begin
          d.zoff[2'(q.trim_idx - 3'(accel_pkg::AXES))] = trim_data;
        end
        if (q.trim_idx == 3'(accel_pkg::TRIM_WORDS - 1)) begin
          d.phase = accel_pkg::RUN;
        end else begin
          d.trim_idx = q.trim_idx + 3'h1;
          d.phase = accel_pkg::TRIM_REQ;
        end
      end
      accel_pkg::RUN: begin
      end
      default: begin
        d.phase = accel_pkg::TRIM_REQ;
      end
    endcase

    if (take) begin
      d.sample = cooked;
      set_flags[accel_pkg::EV_DRDY] = 1'b1;

      // Freefall counter: event fires once per run (on every later low sample too for a count of 255), on the low sample after the run reaches the set count
      if (q.ff_cfg[accel_pkg::FF_CFG_ENABLE] && all_low) begin
        if (q.ff_cnt != accel_pkg::FF_CNT_MAX) begin
          d.ff_cnt = q.ff_cnt + 8'h01;
        end
        ff_evt = (q.ff_cnt == q.ff_count);
      end else begin
        d.ff_cnt = 8'h00;
      end

      // Portrait/landscape only moves while tilted enough; back/front always tracks z
      if (!z_locked) begin
        if (!q.orient[2] && to_landscape) begin
          landscape = 1'b1;
        end else if (q.orient[2] && to_portrait) begin
          landscape = 1'b0;
        end
      end
      new_orient[2] = landscape;
      new_orient[1] = landscape ? cooked[0][9] : cooked[1][9];
      new_orient[0] = cooked[2][9];
      or_evt = (new_orient != q.orient);
      d.orient = new_orient;

      // Auto wake/sleep counts samples since the last qualifying event
      cnt_next = (q.sleep_cnt == accel_pkg::SLEEP_CNT_MAX) ? q.sleep_cnt :
                 q.sleep_cnt + 9'h001;
      if (!q.cfg2[accel_pkg::CFG2_AUTO_SLEEP]) begin
        d.asleep = 1'b0;
        d.sleep_cnt = 9'h000;
      end else if (ff_evt || or_evt) begin
        d.sleep_cnt = 9'h000;
        if (q.asleep) begin
          d.asleep = 1'b0;
          set_flags[accel_pkg::EV_WAKE_SLEEP] = 1'b1;
        end
      end else if (!q.asleep) begin
        d.sleep_cnt = cnt_next;
        if (cnt_next > {1'b0, q.sleep_to}) begin
          d.asleep = 1'b1;
          d.sleep_cnt = 9'h000;
          set_flags[accel_pkg::EV_WAKE_SLEEP] = 1'b1;
        end
      end
      set_flags[accel_pkg::EV_FREEFALL] = ff_evt;
      set_flags[accel_pkg::EV_ORIENT] = or_evt;
    end

    // ----------------------------------------------------------------
    // Register access
    // ----------------------------------------------------------------
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        accel_pkg::ADDR_X_HI: d.rdata = q.sample[0][9:2];
        accel_pkg::ADDR_Y_HI: d.rdata = q.sample[1][9:2];
        accel_pkg::ADDR_Z_HI: d.rdata = q.sample[2][9:2];
        // In 8-bit-only mode the low bytes carry nothing
        accel_pkg::ADDR_X_LO: d.rdata = q.cfg1[accel_pkg::CFG1_FAST_READ] ? 8'h00 :
                                        {q.sample[0][1:0], 6'h00};
        accel_pkg::ADDR_Y_LO: d.rdata = q.cfg1[accel_pkg::CFG1_FAST_READ] ? 8'h00 :
                                        {q.sample[1][1:0], 6'h00};
        accel_pkg::ADDR_Z_LO: d.rdata = q.cfg1[accel_pkg::CFG1_FAST_READ] ? 8'h00 :
                                        {q.sample[2][1:0], 6'h00};
        accel_pkg::ADDR_SYS_MODE: d.rdata = {6'h00, q.asleep, active};
        accel_pkg::ADDR_EVENT_SRC: begin
          d.rdata = {4'h0, q.flags};
          clr_flags = 4'hf;
        end
        accel_pkg::ADDR_RANGE_CFG: d.rdata = q.range_cfg;
        accel_pkg::ADDR_ORIENT: d.rdata = {4'h0, z_locked, q.orient};
        accel_pkg::ADDR_FF_CFG: d.rdata = q.ff_cfg;
        accel_pkg::ADDR_FF_THRESH: d.rdata = q.ff_thresh;
        accel_pkg::ADDR_FF_COUNT: d.rdata = q.ff_count;
        accel_pkg::ADDR_SLEEP_TO: d.rdata = q.sleep_to;
        accel_pkg::ADDR_PRIMARY_CFG: d.rdata = q.cfg1;
        accel_pkg::ADDR_SECOND_CFG: d.rdata = q.cfg2;
        accel_pkg::ADDR_INT_EN: d.rdata = q.int_en;
        accel_pkg::ADDR_INT_ROUTE: d.rdata = q.int_route;
        accel_pkg::ADDR_X_USER_OFF: d.rdata = q.user_off[0];
        accel_pkg::ADDR_Y_USER_OFF: d.rdata = q.user_off[1];
        accel_pkg::ADDR_Z_USER_OFF: d.rdata = q.user_off[2];
        default: d.rdata = 8'h00;
      endcase
    end

    // Writes stay legal in standby; the front end sees changes on the next clock edge, odr_sel one edge later
    if (reg_req.wr) begin
      unique case (reg_req.addr)
        accel_pkg::ADDR_RANGE_CFG: d.range_cfg = {6'h00, reg_req.wdata[1:0]};
        accel_pkg::ADDR_FF_CFG: d.ff_cfg = reg_req.wdata;
        accel_pkg::ADDR_FF_THRESH: d.ff_thresh = reg_req.wdata;
        accel_pkg::ADDR_FF_COUNT: d.ff_count = reg_req.wdata;
        accel_pkg::ADDR_SLEEP_TO: d.sleep_to = reg_req.wdata;
        accel_pkg::ADDR_PRIMARY_CFG: d.cfg1 = reg_req.wdata;
        accel_pkg::ADDR_SECOND_CFG: d.cfg2 = reg_req.wdata;
        accel_pkg::ADDR_INT_EN: d.int_en = reg_req.wdata;
        accel_pkg::ADDR_INT_ROUTE: d.int_route = reg_req.wdata;
        accel_pkg::ADDR_X_USER_OFF: d.user_off[0] = reg_req.wdata;
        accel_pkg::ADDR_Y_USER_OFF: d.user_off[1] = reg_req.wdata;
        accel_pkg::ADDR_Z_USER_OFF: d.user_off[2] = reg_req.wdata;
        default: begin
        end
      endcase
    end

    // A flag set in the same cycle as its clearing read survives
    d.flags = (q.flags & ~clr_flags) | set_flags;

    // Leaving standby restarts event and sleep state
    if (active && !q.was_active) begin
      d.flags = 4'h0;
      d.asleep = 1'b0;
      d.sleep_cnt = 9'h000;
      d.ff_cnt = 8'h00;
      d.orient = 3'h0;
    end

    // Sleep uses the slow codes 4..7, wake uses the full 3-bit rate field
    d.odr = d.asleep ? {1'b1, q.cfg1[accel_pkg::CFG1_SLEEP_RATE_LO +: 2]} :
            q.cfg1[accel_pkg::CFG1_WAKE_RATE_LO +: 3];

    armed = d.flags & q.int_en[3:0];
    d.pin_one = |(armed & q.int_route[3:0]);
    d.pin_two = |(armed & ~q.int_route[3:0]);

    if (!rstn) begin
      d = '0;
      d.phase = accel_pkg::TRIM_REQ;
      d.gain = {accel_pkg::AXES{accel_pkg::RST_GAIN}};
    end
  end

  always_ff @(posedge mclk) begin
    q <= d;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata = q.rdata;
  assign trim_rd = q.trim_rd;
  assign trim_addr = q.trim_addr;
  assign analog_en = q.cfg1[accel_pkg::CFG1_ACTIVE];
  assign odr_sel = q.odr;
  // 10 = high resolution, 11 = lowest power, passed straight to the front end
  assign oversample_sel = q.cfg2[1:0];
  assign sleep_state = q.asleep;
  assign event_pin_one = q.pin_one;
  assign event_pin_two = q.pin_two;

endmodule
